// *** rtl/tsc_pkg.sv ***
// What this block does
// - each accepted sensitivity write triggers a 50 ms internal sensing reset
// - sensitivity has 32 levels, 0 to 31; larger value means more sensitive
// - level above 31 is dropped at stop: no reset, old level kept
// - at power-up the level starts at 29 with no host action
// - valid write adopts the new level and reloads sensing parameters
package tsc_pkg;
    // ------------------------------------------------------------------
    // level encoding
    // ------------------------------------------------------------------
    localparam int LEVEL_W = 5;
    localparam int BYTE_W = 8;
    localparam logic [LEVEL_W-1:0] LEVEL_MAX = 5'h1f;
    localparam logic [LEVEL_W-1:0] LEVEL_RESET = 5'h1d;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_KHZ = 125_000;
    localparam int SENS_RESET_MS = 50;
    // least time, already a whole number of cycles at this rate
    localparam int SENS_RESET_CYC = SENS_RESET_MS * CLK_FREQ_KHZ;

    typedef logic [LEVEL_W-1:0] tsc_level_t;
    typedef logic [BYTE_W-1:0] tsc_byte_t;

    typedef enum logic [1:0] {
        TSC_IDLE,
        TSC_ARMED,
        TSC_EXTRA,
        TSC_RESET
    } tsc_state_t;
endpackage : tsc_pkg

// *** rtl/tsc_reset_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsc_reset_timer #(
    parameter int CYCLES = tsc_pkg::SENS_RESET_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    tsc_timer_if.tmr tif
);
    import tsc_pkg::*;

    localparam int CNT_W = $clog2(CYCLES + 1);

    // ------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------
    generate
        if (CYCLES < 1) begin : g_bad_cycles
            $error("tsc_reset_timer: CYCLES must be at least one");
        end
    endgenerate

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic done_q;
    logic next_done;

    // ------------------------------------------------------------------
    // down counter; a start while running is ignored, the caller never does it
    // ------------------------------------------------------------------
    always_comb begin
        next_count = count;
        next_done = 1'b0;
        if (count != '0) begin
            next_count = count - CNT_W'(1);
            if (count == CNT_W'(1)) begin
                next_done = 1'b1; // last cycle of the interval
            end
        end else if (tif.start) begin
            next_count = CNT_W'(CYCLES);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count <= '0;
            done_q <= 1'b0;
        end else begin
            count <= next_count;
            done_q <= next_done;
        end
    end

    assign tif.active = (count != '0);
    assign tif.done = done_q;
endmodule // tsc_reset_timer
`default_nettype wire

// *** rtl/tsc_sens_cfg.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsc_sens_cfg #(
    parameter int RESET_CYCLES = tsc_pkg::SENS_RESET_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wr_start,
    input wire logic wr_byte_valid,
    input wire tsc_pkg::tsc_byte_t wr_byte,
    input wire logic wr_stop,
    output tsc_pkg::tsc_level_t sens_level,
    output logic sense_reset,
    output logic param_load,
    output logic write_rejected
);
    import tsc_pkg::*;

    // ------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------
    generate
        if (RESET_CYCLES < 1) begin : g_bad_reset
            $error("tsc_sens_cfg: RESET_CYCLES must be at least one");
        end
        // the level is cut from the low end of the data byte
        if (LEVEL_W > BYTE_W) begin : g_bad_level_w
            $error("tsc_sens_cfg: level field wider than the data byte");
        end
        if (LEVEL_RESET > LEVEL_MAX) begin : g_bad_default
            $error("tsc_sens_cfg: default level above the top level");
        end
    endgenerate

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // any byte value up to the top level is a legal setting
    function automatic logic level_ok(input tsc_byte_t b);
        return b <= BYTE_W'(LEVEL_MAX);
    endfunction

    tsc_timer_if tif ();

    tsc_reset_timer #(
        .CYCLES(RESET_CYCLES)
    ) u_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .tif(tif)
    );

    tsc_state_t state;
    tsc_state_t next_state;
    tsc_byte_t held;
    tsc_byte_t next_held;
    tsc_level_t level;
    tsc_level_t next_level;
    logic load_q;
    logic next_load;
    logic rej_q;
    logic next_rej;
    logic start_q;
    logic next_start;

    // ------------------------------------------------------------------
    // frame decode
    // ------------------------------------------------------------------
    // a frame is open once its first data byte has been held
    function automatic logic frame_open(input tsc_state_t st);
        return (st == TSC_ARMED) || (st == TSC_EXTRA);
    endfunction

    logic accept;
    logic reject;

    // the verdict is taken only at stop, from the held first byte; a
    // frame cut short by a repeated start never reaches this point
    always_comb begin
        accept = 1'b0;
        reject = 1'b0;
        if (frame_open(state) && wr_stop) begin
            if (level_ok(held)) begin
                accept = 1'b1;
            end else begin
                reject = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // write sequencing
    // ------------------------------------------------------------------
    // the first data byte of a write is the setting; later bytes are
    // dropped so a runaway master cannot smear the level
    always_comb begin
        next_state = state;
        next_held = held;
        case (state)
            TSC_IDLE: begin
                // a stop with no byte held lands here and is ignored
                if (wr_byte_valid) begin
                    next_held = wr_byte;
                    next_state = TSC_ARMED;
                end
            end
            TSC_ARMED, TSC_EXTRA: begin
                if (accept) begin
                    next_state = TSC_RESET;
                end else if (reject) begin
                    next_state = TSC_IDLE;
                end else if (wr_start) begin
                    next_state = TSC_IDLE; // repeated start abandons the byte
                end else if (wr_byte_valid) begin
                    next_state = TSC_EXTRA;
                end
            end
            TSC_RESET: begin
                // bus traffic inside the interval is ignored; the host
                // is expected to stay off the bus until it ends. leaving on
                // the end pulse keeps one quiet cycle after sense_reset falls
                if (tif.done) begin
                    next_state = TSC_IDLE;
                end
            end
            default: begin
                next_state = TSC_IDLE;
            end
        endcase
    end

    // sequencer registers; a power-on reset drops any half-received frame
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= TSC_IDLE;
            held <= 8'h00;
        end else begin
            state <= next_state;
            held <= next_held;
        end
    end

    // ------------------------------------------------------------------
    // sensitivity level
    // ------------------------------------------------------------------
    // the level moves only on an accepted write; a rejected or cut frame
    // leaves the previous setting in force
    always_comb begin
        next_level = level;
        if (accept) begin
            next_level = held[LEVEL_W-1:0];
        end
    end

    // level comes up at the default value on every power-on reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            level <= LEVEL_RESET;
        end else begin
            level <= next_level;
        end
    end

    // ------------------------------------------------------------------
    // one-cycle pulses
    // ------------------------------------------------------------------
    // reload, timer start and reject are each one registered cycle, so
    // the sensing side sees the new level and the reload together
    always_comb begin
        next_load = accept;
        next_start = accept;
        next_rej = reject;
    end

    // pulse registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            load_q <= 1'b0;
            rej_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            load_q <= next_load;
            rej_q <= next_rej;
            start_q <= next_start;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign tif.start = start_q;
    assign sens_level = level;
    assign sense_reset = start_q | tif.active;
    assign param_load = load_q;
    assign write_rejected = rej_q;
endmodule // tsc_sens_cfg
`default_nettype wire

// *** rtl/tsc_timer_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// start pulse in, running level and end pulse out
interface tsc_timer_if;
    logic start;
    logic active;
    logic done;

    modport ctl (output start, input active, input done);
    modport tmr (input start, output active, output done);
endinterface : tsc_timer_if
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tsc_pkg::*;
    localparam int RC = 20;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    wire logic wr_start, wr_byte_valid, wr_stop;
    wire tsc_byte_t wr_byte;
    tsc_level_t sens_level;
    logic sense_reset, param_load, write_rejected;
    tsc_level_t lvl = LEVEL_RESET;
    int errors = 0;
    int num_checks = 0;
    int n;
    tsc_sens_cfg #(.RESET_CYCLES(RC)) tsc_sens_cfg_inst (.ref_clk(ref_clk), .rst(rst),
        .wr_start(wr_start), .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte),
        .wr_stop(wr_stop), .sens_level(sens_level), .sense_reset(sense_reset),
        .param_load(param_load), .write_rejected(write_rejected));
    tsc_host tsc_host_inst (.ref_clk(ref_clk), .wr_start(wr_start),
        .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte), .wr_stop(wr_stop));
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    function automatic logic in_range(input tsc_byte_t b);
        return b <= 8'h1f;
    endfunction
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // one write, results one edge after stop, then wait out the hold
    task automatic run(input tsc_byte_t b, input logic cancel, input logic extra);
        logic ok;
        tsc_host_inst.write(b, cancel, extra);
        ok = in_range(b) && !cancel;
        if (ok) begin
            lvl = b[4:0];
        end
        chk("param_load", param_load, ok);
        chk("write_rejected", write_rejected, !in_range(b) && !cancel);
        chk("sens_level", sens_level, lvl);
        n = 0;
        while (sense_reset === 1'b1 && n < RC + 5) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= RC + 5) begin
            errors++; // hold never ended
            conclude();
        end
        chk("hold", n[7:0], 8'(ok ? RC + 1 : 0));
        repeat (2) @(negedge ref_clk);
    endtask
    initial begin
        void'($urandom(32'h97cd_2cea));
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        chk("sens_level", sens_level, LEVEL_RESET);
        chk("sense_reset", sense_reset, 1'b0);
        run(8'h00, 1'b0, 1'b0);
        run(8'h1f, 1'b0, 1'b0);
        run(8'h20, 1'b0, 1'b0);
        run(8'hff, 1'b0, 1'b0);
        run(8'h0a, 1'b1, 1'b0);
        run(8'h0c, 1'b0, 1'b1); // second byte out of range, first wins
        run(8'hf3, 1'b0, 1'b1); // second byte in range, first still rejected
        // reset in mid-hold drops the hold and restores the default level
        tsc_host_inst.write(8'h05, 1'b0, 1'b0);
        repeat (4) @(negedge ref_clk);
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        lvl = LEVEL_RESET;
        chk("sens_level", sens_level, LEVEL_RESET);
        chk("sense_reset", sense_reset, 1'b0);
        run(8'h11, 1'b0, 1'b0);
        repeat (8) run(8'($urandom_range(0, 63)), $urandom_range(0, 3) == 0,
            $urandom_range(0, 3) == 1);
        conclude();
    end
endmodule // tb
`default_nettype wire

// *** testbench/tsc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsc_host (
    input wire logic ref_clk,
    output logic wr_start,
    output logic wr_byte_valid,
    output tsc_pkg::tsc_byte_t wr_byte,
    output logic wr_stop
);
    import tsc_pkg::*;
    // bus idle from time zero
    initial begin
        wr_start = 1'b0;
        wr_byte_valid = 1'b0;
        wr_byte = 8'h00;
        wr_stop = 1'b0;
    end
    // one frame: a level byte, an optional second byte, optional restart, then stop
    task automatic write(input tsc_byte_t b, input logic cancel, input logic extra);
        @(negedge ref_clk);
        wr_byte_valid = 1'b1;
        wr_byte = b;
        if (extra) begin
            // a second byte, which must not replace the first
            @(negedge ref_clk);
            wr_byte = ~b;
        end
        @(negedge ref_clk);
        wr_byte_valid = 1'b0;
        wr_byte = ~b; // released data must not look valid
        wr_start = cancel;
        @(negedge ref_clk);
        wr_start = 1'b0;
        wr_stop = 1'b1;
        @(negedge ref_clk);
        wr_stop = 1'b0;
    endtask
endmodule // tsc_host
`default_nettype wire

// *** testbench/tsc_sens_cfg_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsc_sens_cfg_props #(
    parameter int RESET_CYCLES = tsc_pkg::SENS_RESET_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wr_stop,
    input wire tsc_pkg::tsc_level_t sens_level,
    input wire logic sense_reset,
    input wire logic param_load,
    input wire logic write_rejected
);
    import tsc_pkg::*;
    int span;
    int next_span;
    // cycles of the current hold; too long for a repetition
    always_comb begin
        next_span = sense_reset ? span + 1 : 0;
    end
    always_ff @(posedge ref_clk) begin
        span <= rst ? 0 : next_span;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_power_level: assert property ($fell(rst) |-> sens_level == LEVEL_RESET && !sense_reset)
        else $error("level after reset wrong");
    a_hold_span: assert property ($fell(sense_reset) && !$past(rst) |-> span == RESET_CYCLES + 1)
        else $error("reset hold length wrong");
    a_load_start: assert property (param_load |-> $rose(sense_reset) && $past(wr_stop))
        else $error("reload without stop or hold");
    a_load_pulse: assert property (param_load |=> !param_load)
        else $error("reload pulse too long");
    a_reject_quiet: assert property (write_rejected |-> $past(wr_stop) && !sense_reset && $stable(sens_level))
        else $error("rejected write had effect");
    a_level_cause: assert property ($changed(sens_level) && !$past(rst) |-> param_load)
        else $error("level changed without reload");
endmodule // tsc_sens_cfg_props
bind tsc_sens_cfg tsc_sens_cfg_props #(.RESET_CYCLES(RESET_CYCLES)) tsc_sens_cfg_props_inst (
    .ref_clk(ref_clk), .rst(rst), .wr_stop(wr_stop), .sens_level(sens_level),
    .sense_reset(sense_reset), .param_load(param_load), .write_rejected(write_rejected));
`default_nettype wire
